// [common/irc_pkg.sv]
// Purpose: Shared constants and types for the interrupt and reset control block
// Assumes: APB slave with 8-bit byte address, 32-bit data, 20 MHz clock
// Notes: Oscillator clock is taken to be the block clock
package irc_pkg;

  // ==========================================================================
  // Register map (printed offsets are word indices, byte address is index * 4)
  localparam logic [7:0] IDX_IRQ_CONTROL = 8'h1E;
  localparam logic [7:0] IDX_TOP_PRIORITY = 8'h1F;
  localparam logic [7:0] IDX_WDOG_CTRL = 8'h16;
  localparam logic [7:0] IDX_WDOG_SERVICE = 8'h17;
  localparam logic [7:0] IDX_STATUS = 8'h15;
  localparam logic [7:0] ADDR_IRQ_CONTROL = 8'(IDX_IRQ_CONTROL << 2);
  localparam logic [7:0] ADDR_TOP_PRIORITY = 8'(IDX_TOP_PRIORITY << 2);
  localparam logic [7:0] ADDR_WDOG_CTRL = 8'(IDX_WDOG_CTRL << 2);
  localparam logic [7:0] ADDR_WDOG_SERVICE = 8'(IDX_WDOG_SERVICE << 2);
  localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS << 2);

  // ==========================================================================
  // Fields and reset values
  localparam int unsigned BIT_EDGE_SEL = 7;
  localparam int unsigned BIT_PIN_CONNECT = 6;
  localparam int unsigned BIT_STOP_DLY = 5;
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h60;
  localparam logic [7:0] TOP_PRIORITY_RST = 8'hF2;
  localparam int unsigned BIT_WIN_EN = 3;
  localparam int unsigned BIT_CLKMON_EN = 4;
  localparam logic [2:0] WDOG_RATE_LONGEST = 3'h7;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h07;

  // ==========================================================================
  // Vectors and priority
  localparam int unsigned NUM_SRC = 25;
  localparam logic [7:0] VEC_LO_IRQ = 8'hF2;
  localparam logic [7:0] VEC_LO_LAST = 8'hC2;
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_WDOG = 16'hFFFA;
  localparam logic [15:0] VEC_TRAP = 16'hFFF8;
  localparam logic [15:0] VEC_SWI = 16'hFFF6;
  localparam logic [15:0] VEC_NONMASK_IRQ_PIN = 16'hFFF4;
  localparam logic [7:0] VEC_HI = 8'hFF;
  localparam logic [7:0] SVC_FIRST = 8'h55;
  localparam logic [7:0] SVC_SECOND = 8'hAA;

  // ==========================================================================
  // Timing
  localparam int unsigned BUS_DIV = 2;
  localparam logic [4:0] RST_DRIVE_BUS = 5'h10;
  localparam logic [4:0] RST_SAMPLE_BUS = 5'h08;
  localparam logic [12:0] STOP_DLY_OSC = 13'h1000;
  localparam int unsigned WD_BASE_DEF = 1024;

  // Stack frame offsets below the stack pointer
  localparam logic [15:0] OFF_RTN = 16'h0002;
  localparam logic [15:0] OFF_Y = 16'h0004;
  localparam logic [15:0] OFF_X = 16'h0006;
  localparam logic [15:0] OFF_BA = 16'h0008;
  localparam logic [15:0] OFF_CCR = 16'h0009;

  typedef enum logic [1:0] {
    CAUSE_POR = 2'h0, CAUSE_EXT = 2'h1, CAUSE_WDOG = 2'h2, CAUSE_CLKMON = 2'h3
  } irc_cause_e;
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00, RS_DRIVE = 2'b01, RS_WAIT = 2'b11, RS_EXT = 2'b10
  } irc_rst_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PUSH = 3'b001, ST_MASK = 3'b011, ST_VEC = 3'b010,
    ST_POP = 3'b110
  } irc_stk_e;
  typedef enum logic [2:0] {
    SEL_RTN = 3'h0, SEL_Y = 3'h1, SEL_X = 3'h2, SEL_BA = 3'h3, SEL_CCR = 3'h4,
    SEL_VEC = 3'h7
  } irc_sel_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [2:0] sel;
  } irc_stack_s;

endpackage

// [logic/irc_ctrl.sv]
// Purpose: Interrupt priority, interrupt entry sequencing and reset control
// Assumes: All inputs synchronous to clk; oscillator runs at the clk rate
// Notes: One wait state on every APB access; internal resets re-init registers
//
// Implementation choice: the APB slave port.

module irc_ctrl #(
  parameter int unsigned WD_BASE_CYC = irc_pkg::WD_BASE_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_pin_n,
  input wire logic nonmask_irq_pin_n,
  input wire logic ccr_i_mask,
  input wire logic ccr_x_mask,
  input wire logic special_mode_n,
  input wire logic [irc_pkg::NUM_SRC-2:0] mask_req,
  input wire logic swi_req,
  input wire logic trap_req,
  input wire logic cpu_int_start,
  input wire logic cpu_rti,
  input wire logic [15:0] cpu_sp,
  input wire logic stop_wake,
  input wire logic clk_slow_det,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  output logic cpu_rst_n,
  output logic [15:0] reset_vec,
  output logic irq_req_out,
  output logic [7:0] irq_vec_lo,
  output irc_pkg::irc_stack_s stk,
  output logic set_i_mask,
  output logic set_x_mask,
  output logic stop_inhibit_set,
  output logic rti_flag_clr,
  output logic [2:0] rti_rate,
  output logic cpu_resume
);
  import irc_pkg::*;

  // ==========================================================================
  // Declarations
  logic bus_div_reg;
  logic bus_en;
  irc_rst_e rs_state_reg;
  logic [4:0] rs_cnt_reg;
  irc_cause_e cause_reg;
  logic soft_rst;
  logic wd_fire_reg;
  logic cm_fire;
  logic init_reg;
  logic mode_ok_reg;
  logic special_reg;
  logic edge_sel_reg;
  logic pin_connect_reg;
  logic stop_dly_reg;
  logic edge_seen_reg;
  logic dly_seen_reg;
  logic [7:0] top_prio_reg;
  logic [7:0] wd_ctrl_reg;
  logic access;
  logic wr_en;
  logic [7:0] wbyte;
  logic mapped;
  logic [7:0] rd_byte;
  logic irq_pin_d_reg;
  logic irq_latch_reg;
  logic irq_src;
  logic irq_clr;
  logic [NUM_SRC-1:0] req_all;
  logic [4:0] elev_idx;
  logic [4:0] win_idx;
  logic win_found;
  logic mask_any;
  logic nonmask_irq_pin_pend;
  logic [15:0] cand_vec;
  logic pend_any;
  irc_stk_e st_reg;
  logic [2:0] idx_reg;
  logic [15:0] sp_reg;
  logic [15:0] vec_reg;
  logic nonmask_irq_pin_lat_reg;
  logic [23:0] wd_cnt_reg;
  logic [23:0] wd_limit;
  logic wd_enabled;
  logic wd_in_window;
  logic wd_armed_reg;
  logic [12:0] stop_cnt_reg;
  logic stop_busy_reg;

  function automatic logic [15:0] frame_off(input logic [2:0] i);
    logic [15:0] o;
    o = OFF_CCR;
    unique case (i)
      3'h0: o = OFF_RTN;
      3'h1: o = OFF_Y;
      3'h2: o = OFF_X;
      3'h3: o = OFF_BA;
      default: o = OFF_CCR;
    endcase
    return o;
  endfunction

  // ==========================================================================
  // Bus clock enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_div_reg <= 1'b0;
    end else begin
      bus_div_reg <= ~bus_div_reg;
    end
  end
  assign bus_en = bus_div_reg;

  // ==========================================================================
  // Reset sequencing and reset pin
  // Monitor failure outranks the watchdog when both fire together
  assign cm_fire = wd_ctrl_reg[BIT_CLKMON_EN] & clk_slow_det;
  assign soft_rst = (rs_state_reg != RS_IDLE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_state_reg <= RS_IDLE;
      rs_cnt_reg <= 5'h00;
      cause_reg <= CAUSE_POR;
    end else begin
      unique case (rs_state_reg)
        RS_IDLE: begin
          rs_cnt_reg <= 5'h00;
          if (!rst_pin_in) begin
            rs_state_reg <= RS_EXT;
            cause_reg <= CAUSE_EXT;
          end else if (cm_fire || wd_fire_reg) begin
            rs_state_reg <= RS_DRIVE;
            cause_reg <= cm_fire ? CAUSE_CLKMON : CAUSE_WDOG;
          end
        end
        RS_DRIVE: begin
          if (bus_en) begin
            rs_cnt_reg <= 5'(rs_cnt_reg + 5'h01);
            if (rs_cnt_reg == 5'(RST_DRIVE_BUS - 5'h01)) begin
              rs_state_reg <= RS_WAIT;
              rs_cnt_reg <= 5'h00;
            end
          end
        end
        RS_WAIT: begin
          if (bus_en) begin
            rs_cnt_reg <= 5'(rs_cnt_reg + 5'h01);
            if (rs_cnt_reg == 5'(RST_SAMPLE_BUS - 5'h01)) begin
              // Pin still low: someone outside holds it, so the reset is external
              if (!rst_pin_in) begin
                rs_state_reg <= RS_EXT;
                cause_reg <= CAUSE_EXT;
              end else begin
                rs_state_reg <= RS_IDLE;
              end
            end
          end
        end
        RS_EXT: begin
          if (rst_pin_in) begin
            rs_state_reg <= RS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= 1'b1;
      cpu_rst_n <= 1'b0;
      reset_vec <= VEC_RESET;
    end else begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= (rs_state_reg != RS_DRIVE);
      cpu_rst_n <= (rs_state_reg == RS_IDLE);
      unique case (cause_reg)
        CAUSE_WDOG: reset_vec <= VEC_WDOG;
        CAUSE_CLKMON: reset_vec <= VEC_CLKMON;
        default: reset_vec <= VEC_RESET;
      endcase
    end
  end

  // ==========================================================================
  // Mode strap capture, taken after reset release rather than under it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ok_reg <= 1'b0;
      special_reg <= 1'b0;
    end else if (soft_rst) begin
      mode_ok_reg <= 1'b0;
    end else if (!mode_ok_reg) begin
      mode_ok_reg <= 1'b1;
      special_reg <= ~special_mode_n;
    end
  end

  // ==========================================================================
  // APB slave, one wait state so read data comes from a flop
  assign access = psel & penable;
  assign wr_en = access & pwrite & pready;
  assign wbyte = pwdata[7:0];
  assign mapped = (paddr == ADDR_IRQ_CONTROL) || (paddr == ADDR_TOP_PRIORITY) ||
                  (paddr == ADDR_WDOG_CTRL) || (paddr == ADDR_WDOG_SERVICE) ||
                  (paddr == ADDR_STATUS);

  always_comb begin
    rd_byte = 8'h00;
    unique case (paddr)
      ADDR_IRQ_CONTROL: rd_byte = {edge_sel_reg, pin_connect_reg, stop_dly_reg, 5'h00};
      ADDR_TOP_PRIORITY: rd_byte = top_prio_reg;
      ADDR_WDOG_CTRL: rd_byte = wd_ctrl_reg;
      ADDR_STATUS: rd_byte = {3'h0, special_reg, irq_req_out, stop_busy_reg, cause_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access && !pready) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================================================
  // Interrupt control register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_sel_reg <= IRQ_CONTROL_RST[BIT_EDGE_SEL];
      pin_connect_reg <= IRQ_CONTROL_RST[BIT_PIN_CONNECT];
      stop_dly_reg <= IRQ_CONTROL_RST[BIT_STOP_DLY];
      edge_seen_reg <= 1'b0;
      dly_seen_reg <= 1'b0;
    end else if (soft_rst) begin
      edge_sel_reg <= IRQ_CONTROL_RST[BIT_EDGE_SEL];
      pin_connect_reg <= IRQ_CONTROL_RST[BIT_PIN_CONNECT];
      stop_dly_reg <= IRQ_CONTROL_RST[BIT_STOP_DLY];
      edge_seen_reg <= 1'b0;
      dly_seen_reg <= 1'b0;
    end else if (wr_en && paddr == ADDR_IRQ_CONTROL && mode_ok_reg) begin
      edge_seen_reg <= 1'b1;
      dly_seen_reg <= 1'b1;
      if (special_reg ? edge_seen_reg : !edge_seen_reg) begin
        edge_sel_reg <= wbyte[BIT_EDGE_SEL];
      end
      pin_connect_reg <= wbyte[BIT_PIN_CONNECT];
      if (special_reg || !dly_seen_reg) begin
        stop_dly_reg <= wbyte[BIT_STOP_DLY];
      end
    end
  end

  // Top-priority select; silently ignored while the CPU accepts interrupts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      top_prio_reg <= TOP_PRIORITY_RST;
    end else if (soft_rst) begin
      top_prio_reg <= TOP_PRIORITY_RST;
    end else if (wr_en && paddr == ADDR_TOP_PRIORITY && ccr_i_mask) begin
      top_prio_reg <= wbyte;
    end
  end

  // Watchdog and periodic-rate control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_ctrl_reg <= WDOG_CTRL_RST;
    end else if (soft_rst) begin
      wd_ctrl_reg <= WDOG_CTRL_RST;
    end else if (wr_en && paddr == ADDR_WDOG_CTRL) begin
      wd_ctrl_reg <= wbyte;
    end
  end

  // ==========================================================================
  // IRQ pin conditioning
  assign irq_clr = (st_reg == ST_VEC) && (vec_reg == {VEC_HI, VEC_LO_IRQ});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_pin_d_reg <= 1'b1;
      irq_latch_reg <= 1'b0;
    end else begin
      irq_pin_d_reg <= irq_pin_n;
      // A new falling edge beats the service clear in the same cycle
      if (irq_pin_d_reg && !irq_pin_n) begin
        irq_latch_reg <= 1'b1;
      end else if (irq_clr || soft_rst) begin
        irq_latch_reg <= 1'b0;
      end
    end
  end

  assign irq_src = pin_connect_reg & (edge_sel_reg ? irq_latch_reg : ~irq_pin_n);
  assign req_all = {mask_req, irq_src};

  // ==========================================================================
  // Maskable priority resolution
  always_comb begin
    elev_idx = 5'h00;
    if (top_prio_reg >= VEC_LO_LAST && top_prio_reg <= VEC_LO_IRQ && !top_prio_reg[0]) begin
      elev_idx = 5'((VEC_LO_IRQ - top_prio_reg) >> 1);
    end
  end

  always_comb begin
    win_idx = 5'h00;
    win_found = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (!win_found && req_all[i]) begin
        win_idx = 5'(i);
        win_found = 1'b1;
      end
    end
    if (req_all[elev_idx]) begin
      win_idx = elev_idx;
    end
  end

  assign mask_any = win_found & ~ccr_i_mask;
  assign nonmask_irq_pin_pend = ~nonmask_irq_pin_n & ~ccr_x_mask;

  // Nothing pending at entry falls back to the software-interrupt vector
  always_comb begin
    cand_vec = VEC_SWI;
    if (trap_req) begin
      cand_vec = VEC_TRAP;
    end else if (swi_req) begin
      cand_vec = VEC_SWI;
    end else if (nonmask_irq_pin_pend) begin
      cand_vec = VEC_NONMASK_IRQ_PIN;
    end else if (mask_any) begin
      cand_vec = {VEC_HI, 8'(VEC_LO_IRQ - {win_idx, 1'b0})};
    end
  end
  assign pend_any = trap_req | swi_req | nonmask_irq_pin_pend | mask_any;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_out <= 1'b0;
      irq_vec_lo <= VEC_LO_IRQ;
    end else begin
      irq_req_out <= mask_any;
      irq_vec_lo <= 8'(VEC_LO_IRQ - {win_idx, 1'b0});
    end
  end

  // ==========================================================================
  // Interrupt entry and return sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_IDLE;
      idx_reg <= 3'h0;
      sp_reg <= 16'h0000;
      vec_reg <= VEC_SWI;
      nonmask_irq_pin_lat_reg <= 1'b0;
      stk <= '0;
    end else if (soft_rst) begin
      st_reg <= ST_IDLE;
      stk <= '0;
    end else begin
      stk.valid <= 1'b0;
      unique case (st_reg)
        ST_IDLE: begin
          if (cpu_int_start) begin
            st_reg <= ST_PUSH;
            idx_reg <= 3'h0;
            sp_reg <= cpu_sp;
            vec_reg <= cand_vec;
            nonmask_irq_pin_lat_reg <= nonmask_irq_pin_pend;
          end else if (cpu_rti) begin
            sp_reg <= cpu_sp;
            if (pend_any) begin
              vec_reg <= cand_vec;
              st_reg <= ST_VEC;
            end else begin
              st_reg <= ST_POP;
              idx_reg <= 3'h4;
            end
          end
        end
        ST_PUSH: begin
          stk <= '{valid: 1'b1, write: 1'b1, addr: 16'(sp_reg - frame_off(idx_reg)),
                   sel: idx_reg};
          idx_reg <= 3'(idx_reg + 3'h1);
          if (idx_reg == 3'h4) begin
            st_reg <= ST_MASK;
          end
        end
        ST_MASK: begin
          st_reg <= ST_VEC;
        end
        ST_VEC: begin
          stk <= '{valid: 1'b1, write: 1'b0, addr: vec_reg, sel: SEL_VEC};
          st_reg <= ST_IDLE;
        end
        ST_POP: begin
          stk <= '{valid: 1'b1, write: 1'b0,
                   addr: 16'(sp_reg + OFF_CCR - frame_off(idx_reg)), sel: idx_reg};
          idx_reg <= 3'(idx_reg - 3'h1);
          if (idx_reg == 3'h0) begin
            st_reg <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Mask-set pulses: I and X once after every reset; I after the frame is stacked, X too for a nonmask pin entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_reg <= 1'b1;
      set_i_mask <= 1'b0;
      set_x_mask <= 1'b0;
      stop_inhibit_set <= 1'b0;
      rti_flag_clr <= 1'b0;
    end else begin
      init_reg <= soft_rst;
      set_i_mask <= init_reg | (st_reg == ST_MASK);
      set_x_mask <= init_reg | ((st_reg == ST_MASK) & nonmask_irq_pin_lat_reg);
      stop_inhibit_set <= init_reg;
      rti_flag_clr <= init_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rti_rate <= 3'h0;
    end else begin
      rti_rate <= wd_ctrl_reg[7:5];
    end
  end

  // ==========================================================================
  // Watchdog
  assign wd_enabled = (wd_ctrl_reg[2:0] != 3'h0);
  assign wd_limit = 24'(WD_BASE_CYC) << wd_ctrl_reg[2:0];
  assign wd_in_window = (wd_cnt_reg >= 24'(wd_limit - (wd_limit >> 2)));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_reg <= 24'h00_0000;
      wd_armed_reg <= 1'b0;
      wd_fire_reg <= 1'b0;
    end else if (soft_rst) begin
      wd_cnt_reg <= 24'h00_0000;
      wd_armed_reg <= 1'b0;
      wd_fire_reg <= 1'b0;
    end else begin
      wd_fire_reg <= 1'b0;
      if (wd_enabled && bus_en) begin
        wd_cnt_reg <= 24'(wd_cnt_reg + 24'h00_0001);
        if (wd_cnt_reg >= 24'(wd_limit - 24'h00_0001)) begin
          wd_fire_reg <= 1'b1;
        end
      end
      if (wr_en && paddr == ADDR_WDOG_SERVICE && wd_enabled) begin
        if (wd_ctrl_reg[BIT_WIN_EN] && !wd_in_window) begin
          wd_fire_reg <= 1'b1;
        end else if (wbyte == SVC_FIRST) begin
          wd_armed_reg <= 1'b1;
        end else if (wbyte == SVC_SECOND && wd_armed_reg) begin
          wd_armed_reg <= 1'b0;
          wd_cnt_reg <= 24'h00_0000;
        end else begin
          wd_fire_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Stop exit; delay 0 assumes an already stable external oscillator
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_cnt_reg <= 13'h0000;
      stop_busy_reg <= 1'b0;
      cpu_resume <= 1'b0;
    end else begin
      cpu_resume <= 1'b0;
      if (stop_busy_reg) begin
        stop_cnt_reg <= 13'(stop_cnt_reg + 13'h0001);
        if (stop_cnt_reg == 13'(STOP_DLY_OSC - 13'h0001)) begin
          stop_busy_reg <= 1'b0;
          cpu_resume <= 1'b1;
        end
      end else if (stop_wake) begin
        stop_cnt_reg <= 13'h0000;
        stop_busy_reg <= stop_dly_reg;
        cpu_resume <= ~stop_dly_reg;
      end
    end
  end

endmodule

// [tb/irc_ctrl_chk.sv]
// Purpose: Port assertions for irc_ctrl
// Assumes: One clock, arst_n active low
// Notes: Reset pin window allows a few cycles of bus clock phase slack
module irc_ctrl_chk (
  input logic clk,
  input logic arst_n,
  input logic psel,
  input logic penable,
  input logic pready,
  input irc_pkg::irc_stack_s stk,
  input logic set_i_mask,
  input logic stop_inhibit_set,
  input logic rst_pin_oe_n,
  input logic cpu_rst_n,
  input logic [15:0] reset_vec,
  input logic [7:0] irq_vec_lo
);
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;
  // ====
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_push_order;
    stk.valid && stk.write && stk.sel == 3'h0 |=> stk.sel == 3'h1 ##1 stk.sel == 3'h2
      ##1 stk.sel == 3'h3 ##1 stk.sel == 3'h4;
  endproperty
  a_push_order: assert property (p_push_order) else $error("stack order");
  property p_push_addr;
    stk.valid && stk.write && stk.sel inside {3'h1, 3'h2, 3'h3, 3'h4}
      |-> stk.addr == $past(stk.addr) - (stk.sel == 3'h4 ? 16'h1 : 16'h2);
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("stack address");
  property p_fetch;
    stk.valid && stk.write && stk.sel == 3'h4 |=> set_i_mask ##1 stk.valid && stk.sel == 3'h7;
  endproperty
  a_fetch: assert property (p_fetch) else $error("mask then fetch");
  property p_pin_drive;
    $fell(rst_pin_oe_n) |-> ##[28:36] $rose(rst_pin_oe_n);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin drive span");
  property p_cpu_hold;
    $rose(rst_pin_oe_n) |-> !cpu_rst_n [*8];
  endproperty
  a_cpu_hold: assert property (p_cpu_hold) else $error("cpu left reset early");
  property p_por;
    $rose(arst_n) |-> irq_vec_lo == VEC_LO_IRQ && reset_vec == VEC_RESET;
  endproperty
  a_por: assert property (p_por) else $error("reset values");
  property p_init_pulse;
    $rose(arst_n) |-> ##[0:1] set_i_mask && stop_inhibit_set;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("mask pulses");
  property p_wait;
    psel && !penable |=> ##1 pready;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  c_fetch: cover property (stk.valid && stk.sel == 3'h7);
  c_pin: cover property ($rose(rst_pin_oe_n));
  c_bus: cover property (pready);
endmodule
bind irc_ctrl irc_ctrl_chk irc_ctrl_chk_i (.clk, .arst_n, .psel, .penable, .pready, .stk,
  .set_i_mask, .stop_inhibit_set, .rst_pin_oe_n, .cpu_rst_n, .reset_vec, .irq_vec_lo);

// [tb/irc_cpu_model.sv]
// Purpose: CPU side: interrupt mask bit and open-drain reset pin
// Assumes: Pull-up on the reset pin
// Notes: External reset pulses are stretched to 40 cycles
module irc_cpu_model (
  input logic clk,
  input logic arst_n,
  input logic set_i_mask,
  input logic [1:0] mask_cmd,
  input logic ext_rst,
  input logic rst_pin_out,
  input logic rst_pin_oe_n,
  output logic ccr_i_mask,
  output logic rst_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] hold_reg;
  // Software sets the mask before touching local enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ccr_i_mask <= 1'b1;
    else if (set_i_mask || mask_cmd == 2'h2) ccr_i_mask <= 1'b1;
    else if (mask_cmd == 2'h1) ccr_i_mask <= 1'b0;
  end
  // Held past the device window so it is never taken for an internal reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hold_reg <= 6'h00;
    else if (ext_rst) hold_reg <= 6'h28;
    else if (hold_reg != 6'h00) hold_reg <= hold_reg - 6'h01;
  end
  assign rst_pin_in = (rst_pin_oe_n | rst_pin_out) & (hold_reg == 6'h00);
endmodule

// [tb/test_irq_priority_and_reset_control.sv]
// Purpose: Self-checking bench for irc_ctrl
// Assumes: 50 ns clock, watchdog base cut to 4
// Notes: Reads and stack writes are checked through queues
module test_irq_priority_and_reset_control;
  timeunit 1ns;
  timeprecision 1ns;
  import irc_pkg::*;
  localparam logic [15:0] RV[4] = '{VEC_WDOG, VEC_WDOG, VEC_CLKMON, VEC_RESET};
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq_pin_n, cpu_int_start;
  logic cpu_rti, stop_wake, clk_slow_det, rst_pin_in, rst_pin_out, rst_pin_oe_n, cpu_rst_n;
  logic cpu_resume, ccr_i_mask, set_i_mask, ext_rst, special_mode_n;
  logic [7:0] paddr, irq_vec_lo, hp;
  logic [31:0] pwdata, prdata;
  logic [23:0] mask_req;
  logic [15:0] cpu_sp, reset_vec, sp;
  logic [1:0] mask_cmd;
  irc_stack_s stk;
  logic [32:0] rd_q[$];
  logic [18:0] stk_q[$];
  int bad_count, compares, k;
  irc_ctrl #(.WD_BASE_CYC(4)) irc_ctrl_i (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_pin_n, .nonmask_irq_pin_n(1'b1), .ccr_i_mask,
    .ccr_x_mask(1'b1), .special_mode_n, .mask_req, .swi_req(1'b0), .trap_req(1'b0),
    .cpu_int_start, .cpu_rti, .cpu_sp, .stop_wake, .clk_slow_det, .rst_pin_in, .rst_pin_out,
    .rst_pin_oe_n, .cpu_rst_n, .reset_vec, .irq_req_out(), .irq_vec_lo, .stk, .set_i_mask,
    .set_x_mask(), .stop_inhibit_set(), .rti_flag_clr(), .rti_rate(), .cpu_resume);
  irc_cpu_model irc_cpu_model_i (.clk, .arst_n, .set_i_mask, .mask_cmd, .ext_rst,
    .rst_pin_out, .rst_pin_oe_n, .ccr_i_mask, .rst_pin_in);
  // ====
  // Helpers
  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    rd_q.push_back({e[8], 24'h0, e[7:0]});
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [7:0] win(input logic [23:0] r, input logic [7:0] h);
    win = 8'h00;
    for (int i = 23; i >= 0; i--) if (r[i]) win = 8'(8'hF0 - 2 * i);
    if (r[(8'hF0 - h) / 2]) win = h;
  endfunction
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      cmp("prdata", rd_q.pop_front(), {pslverr, prdata});
    if (stk.valid === 1'b1 && stk.write && stk_q.size() > 0)
      cmp("stk", 33'(stk_q.pop_front()), 33'({stk.sel, stk.addr}));
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
  // ====
  // Tests
  initial begin
    {arst_n, psel, penable, pwrite, cpu_int_start, cpu_rti, stop_wake, ext_rst} = '0;
    {clk_slow_det, mask_cmd, paddr, pwdata, mask_req, cpu_sp} = '0;
    {irq_pin_n, special_mode_n} = 2'b11;
    void'($urandom(51));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(ADDR_IRQ_CONTROL, 9'h060);
    rd(ADDR_TOP_PRIORITY, 9'h0F2);
    rd(ADDR_WDOG_CTRL, 9'h007);
    rd(8'h00, 9'h100);
    apb(1'b1, ADDR_IRQ_CONTROL, 32'h80);
    apb(1'b1, ADDR_IRQ_CONTROL, 32'h60);
    rd(ADDR_IRQ_CONTROL, 9'h0C0);
    stop_wake <= 1'b1;
    @(posedge clk);
    stop_wake <= 1'b0;
    @(posedge clk);
    cmp("resume", 33'h1, 33'(cpu_resume));
    $display("test registers done");
    apb(1'b1, ADDR_TOP_PRIORITY, 32'hF0);
    mask_cmd <= 2'h1;
    apb(1'b1, ADDR_TOP_PRIORITY, 32'hE0);
    rd(ADDR_TOP_PRIORITY, 9'h0F0);
    mask_cmd <= 2'h2;
    for (k = 0; k < 4; k++) begin
      mask_req <= 24'($urandom) | 24'h800000;
      hp = 8'hF0 - 8'(2 * ($urandom % 24));
      apb(1'b1, ADDR_TOP_PRIORITY, {24'h0, hp});
      repeat (3) @(posedge clk);
      cmp("vec", win(mask_req, hp), irq_vec_lo);
    end
    apb(1'b1, ADDR_TOP_PRIORITY, 32'hF4);
    irq_pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    cmp("vec", 33'hF2, 33'(irq_vec_lo));
    $display("test priority done");
    sp = 16'($urandom) | 16'h0100;
    cpu_sp <= sp;
    cpu_int_start <= 1'b1;
    for (k = 0; k < 4; k++) stk_q.push_back({3'(k), sp - 16'(2 * k + 2)});
    stk_q.push_back({3'h4, sp - 16'h9});
    @(posedge clk);
    cpu_int_start <= 1'b0;
    repeat (12) @(posedge clk);
    cmp("stack left", 33'h0, 33'(stk_q.size()));
    cpu_rti <= 1'b1;
    @(posedge clk);
    cpu_rti <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test stacking done");
    for (k = 0; k < 4; k++) begin
      case (k)
        0: apb(1'b1, ADDR_WDOG_CTRL, 32'h01);
        1: apb(1'b1, ADDR_WDOG_SERVICE, 32'h12);
        2: begin
          clk_slow_det <= 1'b1;
          apb(1'b1, ADDR_WDOG_CTRL, 32'h17);
        end
        default: ext_rst <= 1'b1;
      endcase
      while (cpu_rst_n !== 1'b0) @(posedge clk);
      {clk_slow_det, ext_rst} <= 2'b00;
      while (cpu_rst_n !== 1'b1) @(posedge clk);
      cmp("reset vec", 33'(RV[k]), 33'(reset_vec));
    end
    rd(ADDR_WDOG_CTRL, 9'h007);
    repeat (4) @(posedge clk);
    $display("test resets done");
    close_out();
  end
endmodule
